//--- design/lstc_trigger_ctrl.sv
// Frame and line start trigger control with rescaler and statistics
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lstc_trigger_ctrl
  import lstc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ext_trigger_input_a,
  input wire logic i_ext_trigger_input_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_frame_valid,
  output logic o_line_start,
  output logic o_frame_done
);
  lstc_ctrl_type ctrl;
  logic [12:0] height;
  logic [31:0] period_scale_factor;
  logic [31:0] line_per;
  logic [11:0] roi_w;
  lstc_fs_state_type state;
  lstc_fs_state_type next_state;
  logic [12:0] lcnt;
  logic fs_evt;
  logic fs_active;
  logic ls_evt;
  logic ls_level;
  logic fs_level_mode;
  logic [31:0] min_per;
  logic [31:0] eff_per;
  logic [31:0] fr_cnt;
  logic fr_pulse;
  logic fr_run;
  logic trig;
  logic accept;
  logic last;
  logic [31:0] raw_per;
  logic raw_vld;
  lstc_stat_type raw_stat;
  lstc_stat_type sc_stat;
  logic [31:0] raw_pulse_rate_peak;
  logic [5:0] sh;
  logic [40:0] sum;
  logic [31:0] avg;
  logic avg_ok;
  logic [63:0] thr;
  logic [63:0] acc;
  logic [63:0] acc_sum;
  logic sc_pulse;
  logic sc_run;

  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  function automatic lstc_ctrl_type fix_ctrl(input logic [CTRL_W-1:0] raw);
    lstc_ctrl_type c;
    c = lstc_ctrl_type'(raw);
    if (c.fs_act > ACT_LOW) c.fs_act = ACT_RISE;
    if (c.ls_act == 2'b11) c.ls_act = 2'b00;
    if (c.filt_sel > FILT_SEL_MAX) c.filt_sel = FILT_SEL_MAX;
    return c;
  endfunction

  // Software settings
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= lstc_ctrl_type'(CTRL_RST);
      height <= HEIGHT_RST;
      period_scale_factor <= SCALE_RST;
      line_per <= LINE_PER_RST;
      roi_w <= ROI_W_RST;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_CTRL: ctrl <= fix_ctrl(i_wdata[CTRL_W-1:0]);
        ADDR_HEIGHT: height <= 13'(clamp(i_wdata, HEIGHT_MIN, HEIGHT_MAX));
        ADDR_SCALE: period_scale_factor <= clamp(i_wdata, SCALE_MIN, SCALE_MAX);
        ADDR_LINE_PER: line_per <= i_wdata;
        ADDR_ROI_W: roi_w <= i_wdata[11:0];
        default: ;
      endcase
    end
  end

  lstc_trig_detect u_fs_detect (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_in_a(i_ext_trigger_input_a),
    .i_in_b(i_ext_trigger_input_b),
    .i_sel_b(ctrl.fs_src),
    .i_act(ctrl.fs_act),
    .o_event(fs_evt),
    .o_active(fs_active),
    .o_level()
  );

  lstc_trig_detect u_ls_detect (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_in_a(i_ext_trigger_input_a),
    .i_in_b(i_ext_trigger_input_b),
    .i_sel_b(ctrl.ls_src),
    .i_act(lstc_act_type'({1'b0, ctrl.ls_act})),
    .o_event(ls_evt),
    .o_active(),
    .o_level(ls_level)
  );

  // Free-run line rate, never above the readout limit of the ROI width
  assign min_per = READOUT_FIX_CYC + 32'(roi_w >> READOUT_PIX_SHIFT);
  assign eff_per = (line_per > min_per) ? line_per : min_per;
  assign fr_run = ctrl.acq_en & ~ctrl.ls_ext;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fr_cnt <= 32'h0000_0000;
      fr_pulse <= 1'b0;
    end else if (!fr_run) begin
      fr_cnt <= 32'h0000_0000;
      fr_pulse <= 1'b0;
    end else if (fr_cnt >= eff_per - 32'h0000_0001) begin
      fr_cnt <= 32'h0000_0000;
      fr_pulse <= 1'b1;
    end else begin
      fr_cnt <= fr_cnt + 32'h0000_0001;
      fr_pulse <= 1'b0;
    end
  end

  // Jitter filter: running mean of the raw period over 2**sh samples
  assign sh = FILT_BASE_SHIFT + {3'h0, ctrl.filt_sel};
  assign avg = 32'(sum >> sh);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sum <= 41'h000_0000_0000;
      avg_ok <= 1'b0;
    end else if (i_wr && i_addr == ADDR_CTRL) begin
      avg_ok <= 1'b0;
    end else if (raw_vld) begin
      avg_ok <= 1'b1;
      if (!avg_ok) begin
        sum <= {9'h000, raw_per} << sh;
      end else begin
        sum <= sum - (sum >> sh) + {9'h000, raw_per};
      end
    end
  end

  // Rate multiplier: one output pulse each avg*ONE/factor cycles
  assign thr = {32'h0000_0000, avg} * SCALE_ONE;
  assign acc_sum = acc + {32'h0000_0000, period_scale_factor};
  assign sc_run = ctrl.scaler_en & ctrl.ls_ext & avg_ok;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc <= 64'h0000_0000_0000_0000;
      sc_pulse <= 1'b0;
    end else if (!sc_run) begin
      acc <= 64'h0000_0000_0000_0000;
      sc_pulse <= 1'b0;
    end else if (acc_sum >= thr) begin
      acc <= acc_sum - thr;
      sc_pulse <= 1'b1;
    end else begin
      acc <= acc_sum;
      sc_pulse <= 1'b0;
    end
  end

  // Line trigger source selection and frame gating
  assign trig = ctrl.ls_ext ? (ctrl.scaler_en ? sc_pulse : ls_evt)
                            : fr_pulse;
  assign accept = trig & (state == FS_ACTIVE);
  assign last = lcnt == height - 13'h0001;
  assign fs_level_mode = ctrl.fs_ext &
                         (ctrl.fs_act == ACT_HIGH || ctrl.fs_act == ACT_LOW);

  always_comb begin
    next_state = state;
    case (state)
      FS_IDLE: if (ctrl.acq_en) next_state = FS_WAIT;
      FS_WAIT: if (!ctrl.fs_ext || fs_evt) next_state = FS_ACTIVE;
      FS_ACTIVE: begin
        if (fs_level_mode ? !fs_active : (accept && last)) begin
          next_state = FS_WAIT;
        end
      end
      default: next_state = FS_IDLE;
    endcase
    if (!ctrl.acq_en) next_state = FS_IDLE;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= FS_IDLE;
      o_frame_valid <= 1'b0;
    end else begin
      state <= next_state;
      o_frame_valid <= next_state == FS_ACTIVE;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lcnt <= 13'h0000;
      o_line_start <= 1'b0;
      o_frame_done <= 1'b0;
    end else begin
      o_line_start <= accept;
      o_frame_done <= accept & last;
      if (state != FS_ACTIVE) begin
        lcnt <= 13'h0000;
      end else if (accept) begin
        lcnt <= last ? 13'h0000 : lcnt + 13'h0001;
      end
    end
  end

  lstc_pulse_stats u_raw_stats (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_event(ls_evt),
    .i_level(ls_level),
    .o_period(raw_per),
    .o_period_vld(raw_vld),
    .o_stat(raw_stat)
  );

  lstc_pulse_stats u_sc_stats (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_event(sc_pulse),
    .i_level(sc_pulse),
    .o_period(),
    .o_period_vld(),
    .o_stat(sc_stat)
  );

  // Peak rate; writing its address restarts tracking, a new peak wins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      raw_pulse_rate_peak <= 32'h0000_0000;
    end else if (raw_stat.rate > raw_pulse_rate_peak) begin
      raw_pulse_rate_peak <= raw_stat.rate;
    end else if (i_wr && i_addr == ADDR_RAW_PEAK) begin
      raw_pulse_rate_peak <= raw_stat.rate;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (!i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      case (i_addr)
        ADDR_CTRL: o_rdata <= {18'h00000, ctrl};
        ADDR_HEIGHT: o_rdata <= {19'h00000, height};
        ADDR_SCALE: o_rdata <= period_scale_factor;
        ADDR_LINE_PER: o_rdata <= eff_per;
        ADDR_ROI_W: o_rdata <= {20'h00000, roi_w};
        ADDR_RAW_RATE: o_rdata <= raw_stat.rate;
        ADDR_RAW_PEAK: o_rdata <= raw_pulse_rate_peak;
        ADDR_RAW_JIT: o_rdata <= raw_stat.jitter;
        ADDR_RAW_WIDTH: o_rdata <= raw_stat.width;
        ADDR_SC_RATE: o_rdata <= sc_stat.rate;
        ADDR_SC_JIT: o_rdata <= sc_stat.jitter;
        ADDR_STATUS: o_rdata <= (32'(lcnt) << STAT_LCNT_POS) |
                                {29'h0, state, o_frame_valid};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  logic [31:0] gap;
  logic gap_ok;
  logic wr_seen;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap <= 32'h0000_0000;
      gap_ok <= 1'b0;
      wr_seen <= 1'b0;
    end else if (fr_pulse) begin
      gap <= 32'h0000_0000;
      gap_ok <= 1'b1;
      wr_seen <= i_wr;
    end else begin
      gap <= gap + 32'h0000_0001;
      wr_seen <= wr_seen | i_wr | ~fr_run;
    end
  end

  ignore_invalid_a: assert property (
    (trig && state != FS_ACTIVE) |=> !o_line_start)
    else $error("line start taken while frame start invalid");
  ext_line_a: assert property (
    (ctrl.ls_ext && !ctrl.scaler_en && ls_evt && state == FS_ACTIVE)
    |=> o_line_start)
    else $error("external line edge not turned into a line start");
  level_high_a: assert property (
    (state == FS_ACTIVE && ctrl.fs_ext && ctrl.fs_act == ACT_HIGH &&
     ctrl.acq_en && !fs_active) |=> (state == FS_WAIT && !o_frame_valid))
    else $error("frame start stayed valid after input went low");
  level_low_a: assert property (
    (ctrl.fs_ext && ctrl.fs_act == ACT_LOW && ctrl.acq_en) ##0
    (state == FS_ACTIVE && fs_active) |=> o_frame_valid)
    else $error("frame start dropped while input still low");
  frame_end_a: assert property (
    (accept && last && ctrl.acq_en && !fs_level_mode)
    |=> (o_frame_done && !o_frame_valid) ##1 (state != FS_ACTIVE ||
    !ctrl.fs_ext))
    else $error("edge frame start not ended after a full frame");
  free_run_a: assert property (
    (ctrl.acq_en && !ctrl.fs_ext && state == FS_WAIT) |=> o_frame_valid)
    else $error("free run did not revalidate frame start");
  line_period_a: assert property (
    (fr_pulse && gap_ok && !wr_seen) |-> gap == eff_per - 32'h0000_0001)
    else $error("free run line period not the limited period");
  bypass_a: assert property (
    !ctrl.scaler_en |=> !sc_pulse)
    else $error("rescaled pulse while the rescaler is off");
  scaled_drive_a: assert property (
    (ctrl.ls_ext && ctrl.scaler_en && sc_pulse && state == FS_ACTIVE)
    |=> o_line_start)
    else $error("rescaled pulse did not start a line");
  peak_rate_a: assert property (
    ##1 raw_pulse_rate_peak >= $past(raw_stat.rate))
    else $error("peak rate below a reported rate");

  free_frame_c: cover property (!ctrl.fs_ext && o_frame_done);
  level_drop_c: cover property (fs_level_mode ##0 $fell(o_frame_valid));
  scaled_line_c: cover property (ctrl.scaler_en && o_line_start);
  ignored_c: cover property (ls_evt && state == FS_WAIT && ctrl.fs_ext);
endmodule
`default_nettype wire

//--- design/lstc_pkg.sv
// Shared constants and types for the line scan trigger controller
package lstc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int NS_PER_S = 1000000000;
  localparam int NS_PER_US = 1000;
  localparam logic [31:0] CLK_HZ = 32'(NS_PER_S / CLK_PERIOD_NS);
  localparam logic [31:0] CYC_PER_US = 32'(NS_PER_US / CLK_PERIOD_NS);
  localparam logic [31:0] JIT_PCT = 32'h0000_0064;
  localparam logic [63:0] SCALE_ONE = 64'h0000_0000_000F_4240;
  localparam logic [31:0] SCALE_MIN = 32'h0000_2710;
  localparam logic [31:0] SCALE_MAX = 32'h05F5_E100;
  localparam logic [31:0] SCALE_RST = 32'h000F_4240;
  localparam logic [31:0] HEIGHT_MIN = 32'h0000_0001;
  localparam logic [31:0] HEIGHT_MAX = 32'h0000_1000;
  localparam logic [12:0] HEIGHT_RST = 13'h0400;
  localparam logic [31:0] LINE_PER_RST = 32'h0000_07D0;
  localparam logic [11:0] ROI_W_RST = 12'h870;
  localparam logic [31:0] READOUT_FIX_CYC = 32'h0000_0010;
  localparam int READOUT_PIX_SHIFT = 3;
  localparam logic [2:0] FILT_SEL_MAX = 3'h5;
  localparam logic [5:0] FILT_BASE_SHIFT = 6'h04;
  localparam int CTRL_W = 14;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam int STAT_LCNT_POS = 16;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HEIGHT = 8'h04;
  localparam logic [7:0] ADDR_SCALE = 8'h08;
  localparam logic [7:0] ADDR_LINE_PER = 8'h0C;
  localparam logic [7:0] ADDR_ROI_W = 8'h10;
  localparam logic [7:0] ADDR_RAW_RATE = 8'h14;
  localparam logic [7:0] ADDR_RAW_PEAK = 8'h18;
  localparam logic [7:0] ADDR_RAW_JIT = 8'h1C;
  localparam logic [7:0] ADDR_RAW_WIDTH = 8'h20;
  localparam logic [7:0] ADDR_SC_RATE = 8'h24;
  localparam logic [7:0] ADDR_SC_JIT = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;

  typedef enum logic [2:0] {
    ACT_RISE = 3'b000,
    ACT_FALL = 3'b001,
    ACT_ANY = 3'b010,
    ACT_HIGH = 3'b011,
    ACT_LOW = 3'b100
  } lstc_act_type;

  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_WAIT = 2'b01,
    FS_ACTIVE = 2'b10
  } lstc_fs_state_type;

  typedef struct packed {
    logic [2:0] filt_sel;
    logic scaler_en;
    logic [1:0] ls_act;
    logic ls_src;
    logic ls_ext;
    lstc_act_type fs_act;
    logic fs_src;
    logic fs_ext;
    logic acq_en;
  } lstc_ctrl_type;

  typedef struct packed {
    logic [31:0] rate;
    logic [31:0] jitter;
    logic [31:0] width;
  } lstc_stat_type;
endpackage

//--- design/lstc_trig_detect.sv
// Input line selection and activation detection
`timescale 1ns/1ps
`default_nettype none
module lstc_trig_detect
  import lstc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_in_a,
  input wire logic i_in_b,
  input wire logic i_sel_b,
  input wire lstc_act_type i_act,
  output logic o_event,
  output logic o_active,
  output logic o_level
);
  logic prev;
  logic cur;
  logic rise;
  logic fall;

  assign cur = i_sel_b ? i_in_b : i_in_a;
  assign rise = cur & ~prev;
  assign fall = ~cur & prev;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev <= 1'b0;
      o_level <= 1'b0;
    end else begin
      prev <= cur;
      o_level <= cur;
    end
  end

  // Level modes enter on the edge into the active level
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_event <= 1'b0;
      o_active <= 1'b0;
    end else begin
      case (i_act)
        ACT_RISE: o_event <= rise;
        ACT_FALL: o_event <= fall;
        ACT_ANY: o_event <= rise | fall;
        ACT_HIGH: o_event <= rise;
        ACT_LOW: o_event <= fall;
        default: o_event <= 1'b0;
      endcase
      case (i_act)
        ACT_HIGH: o_active <= cur;
        ACT_LOW: o_active <= ~cur;
        default: o_active <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- design/lstc_pulse_stats.sv
// Period, rate, jitter and pulse width measurement of a pulse stream
`timescale 1ns/1ps
`default_nettype none
module lstc_pulse_stats
  import lstc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_event,
  input wire logic i_level,
  output logic [31:0] o_period,
  output logic o_period_vld,
  output lstc_stat_type o_stat
);
  logic [31:0] cnt;
  logic [31:0] per_now;
  logic [31:0] dev;
  logic [31:0] jnum;
  logic [31:0] wcnt;
  logic [31:0] wlat;
  logic seen;
  logic lvl_d;
  logic busy;
  logic fin;
  logic [1:0] op;
  logic [4:0] bitc;
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] quo;
  logic [32:0] rem;
  logic [32:0] rem_s;
  logic ge;

  assign per_now = cnt + 32'h0000_0001;
  assign jnum = (dev[31:24] != 8'h00) ? 32'hFFFF_FFFF :
                32'({8'h00, dev[23:0]} * JIT_PCT);
  assign rem_s = {rem[31:0], num[31]};
  assign ge = rem_s >= {1'b0, den};

  // Period between events, saturating on a stalled input
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 32'h0000_0000;
      o_period <= 32'h0000_0000;
      o_period_vld <= 1'b0;
      dev <= 32'h0000_0000;
      seen <= 1'b0;
    end else begin
      o_period_vld <= i_event & seen;
      if (i_event) begin
        cnt <= 32'h0000_0000;
        seen <= 1'b1;
        o_period <= per_now;
        dev <= (per_now > o_period) ? per_now - o_period : o_period - per_now;
      end else if (cnt != 32'hFFFF_FFFE) begin
        cnt <= per_now;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_d <= 1'b0;
      wcnt <= 32'h0000_0000;
      wlat <= 32'h0000_0000;
    end else begin
      lvl_d <= i_level;
      if (i_level && wcnt != 32'hFFFF_FFFF) begin
        wcnt <= wcnt + 32'h0000_0001;
      end else if (!i_level) begin
        wcnt <= 32'h0000_0000;
      end
      if (lvl_d && !i_level) begin
        wlat <= wcnt;
      end
    end
  end

  // One serial divider runs rate, jitter and width in turn
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy <= 1'b0;
      fin <= 1'b0;
      op <= 2'b00;
      bitc <= 5'h00;
      num <= 32'h0000_0000;
      den <= 32'h0000_0001;
      quo <= 32'h0000_0000;
      rem <= 33'h0_0000_0000;
      o_stat <= '0;
    end else begin
      fin <= 1'b0;
      if (busy) begin
        rem <= ge ? rem_s - {1'b0, den} : rem_s;
        quo <= {quo[30:0], ge};
        num <= {num[30:0], 1'b0};
        bitc <= bitc - 5'h01;
        if (bitc == 5'h00) begin
          busy <= 1'b0;
          fin <= 1'b1;
        end
      end else if (fin) begin
        case (op)
          2'b00: o_stat.rate <= quo;
          2'b01: o_stat.jitter <= quo;
          default: o_stat.width <= quo;
        endcase
        if (op != 2'b10) begin
          op <= op + 2'b01;
          num <= (op == 2'b00) ? jnum : wlat;
          den <= (op == 2'b00) ? o_period : CYC_PER_US;
          rem <= 33'h0_0000_0000;
          quo <= 32'h0000_0000;
          bitc <= 5'h1F;
          busy <= 1'b1;
        end
      end else if (o_period_vld) begin
        op <= 2'b00;
        num <= CLK_HZ;
        den <= o_period;
        rem <= 33'h0_0000_0000;
        quo <= 32'h0000_0000;
        bitc <= 5'h1F;
        busy <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/lstc_pulse_src.sv
// Model of the external trigger source on both input lines
`timescale 1ns/1ps
`default_nettype none
module lstc_pulse_src (
  input wire logic i_clk,
  output logic o_line_a,
  output logic o_line_b
);
  initial begin
    o_line_a = 1'b0;
    o_line_b = 1'b0;
  end
  // Hold one line at a level; the source feeds frame and line inputs
  task automatic drive(input logic sel, input logic lvl, input int cyc);
    @(posedge i_clk);
    if (sel) begin
      o_line_b <= lvl;
    end else begin
      o_line_a <= lvl;
    end
    repeat (cyc - 1) @(posedge i_clk);
  endtask
  task automatic pulse(input logic sel, input int hi, input int lo);
    drive(sel, 1'b1, hi);
    drive(sel, 1'b0, lo);
  endtask
endmodule
`default_nettype wire

//--- tb/line_scan_trigger_control_tb_top.sv
// Self-checking bench for the line scan trigger controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, a); end end
module line_scan_trigger_control_tb_top;
  import lstc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic fv, ls, fd, lin_a, lin_b;
  int bad_count = 0;
  int cmp_count = 0;
  int ls_cnt = 0;
  int fd_cnt = 0;
  int n0, d0;
  lstc_pulse_src src (.i_clk(clk), .o_line_a(lin_a), .o_line_b(lin_b));
  lstc_trigger_ctrl uut (.i_clk(clk), .i_arst_n(arst_n),
    .i_ext_trigger_input_a(lin_a), .i_ext_trigger_input_b(lin_b),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_frame_valid(fv), .o_line_start(ls), .o_frame_done(fd));
  initial begin
    forever #25 clk = ~clk;
  end
  // Count on the falling edge, where the registered outputs have settled
  always @(negedge clk) begin
    if (ls === 1'b1) ls_cnt++;
    if (fd === 1'b1) fd_cnt++;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask
  task automatic wait_fv(input logic v);
    for (int i = 0; i < 40 && fv !== v; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("frame valid", v, fv)
    if (fv !== v) close_out();
  endtask
  task automatic t_reset;
    rchk(ADDR_CTRL, 32'h0, "ctrl");
    wreg(ADDR_CTRL, 32'h3B38);
    rchk(ADDR_CTRL, 32'h2800, "ctrl clamp");
    rchk(ADDR_HEIGHT, 32'h400, "height");
    rchk(ADDR_SCALE, SCALE_RST, "scale");
    rchk(ADDR_LINE_PER, 32'h7D0, "line period");
    rchk(8'h30, 32'h0, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_edge;
    wreg(ADDR_HEIGHT, 32'h1);
    for (int m = 0; m < 3; m++) begin
      wreg(ADDR_CTRL, 32'h0C3 | (m << 3));
      n0 = ls_cnt;
      src.pulse(1'b1, 4, 4);
      `CHK("dropped line", n0, ls_cnt)
      src.pulse(1'b0, 4, 4);
      wait_fv(1'b1);
      d0 = fd_cnt;
      src.pulse(1'b1, 4, 4);
      wait_fv(1'b0);
      `CHK("frame done", d0 + 1, fd_cnt)
      `CHK("line count", n0 + 1, ls_cnt)
    end
    $display("edge frame test done");
  endtask
  task automatic t_level;
    wreg(ADDR_HEIGHT, 32'h400);
    for (int k = 0; k < 3; k++) begin
      wreg(ADDR_CTRL, 32'h0DB | (k << 8));
      src.drive(1'b0, 1'b0, 4);
      src.drive(1'b0, 1'b1, 6);
      wait_fv(1'b1);
      n0 = ls_cnt;
      src.pulse(1'b1, 4, 6);
      `CHK("edge lines", n0 + ((k == 2) ? 2 : 1), ls_cnt)
    end
    src.drive(1'b0, 1'b0, 2);
    wait_fv(1'b0);
    // Frame start on line B and line start on line A
    wreg(ADDR_CTRL, 32'h067);
    src.drive(1'b1, 1'b1, 4);
    src.drive(1'b1, 1'b0, 6);
    wait_fv(1'b1);
    src.drive(1'b1, 1'b1, 2);
    wait_fv(1'b0);
    src.drive(1'b1, 1'b0, 2);
    wait_fv(1'b1);
    $display("level frame test done");
  endtask
  task automatic t_free;
    wreg(ADDR_ROI_W, 32'h30);
    wreg(ADDR_LINE_PER, 32'h28);
    rchk(ADDR_LINE_PER, 32'h28, "narrow period");
    wreg(ADDR_ROI_W, 32'h870);
    rchk(ADDR_LINE_PER, 32'h11E, "wide period");
    wreg(ADDR_ROI_W, 32'h30);
    wreg(ADDR_CTRL, 32'h1);
    wait_fv(1'b1);
    n0 = ls_cnt;
    repeat (400) @(posedge clk);
    `CHK("free lines", 1'b1, (ls_cnt - n0 >= 9 && ls_cnt - n0 <= 11))
    wreg(ADDR_CTRL, 32'h0);
    wait_fv(1'b0);
    $display("free run test done");
  endtask
  task automatic t_stats;
    wreg(ADDR_SCALE, 32'h1);
    rchk(ADDR_SCALE, 32'h2710, "scale clamp");
    wreg(ADDR_SCALE, 32'h1E8480);
    src.drive(1'b0, 1'b0, 2);
    wreg(ADDR_CTRL, 32'h0DB);
    src.drive(1'b0, 1'b1, 2);
    wait_fv(1'b1);
    n0 = ls_cnt;
    repeat (12) src.pulse(1'b1, 20, 80);
    `CHK("raw lines", n0 + 12, ls_cnt)
    rchk(ADDR_RAW_RATE, 32'h30D40, "raw rate");
    wreg(ADDR_RAW_PEAK, 32'h0);
    rchk(ADDR_RAW_PEAK, 32'h30D40, "raw peak");
    rchk(ADDR_RAW_JIT, 32'h0, "raw jitter");
    rchk(ADDR_RAW_WIDTH, 32'h1, "raw width");
    src.drive(1'b0, 1'b0, 2);
    wait_fv(1'b0);
    src.drive(1'b0, 1'b1, 2);
    wait_fv(1'b1);
    src.pulse(1'b1, 20, 80);
    // Restart the mean inside a gap so its first sample is a full period
    src.pulse(1'b1, 20, 78);
    wreg(ADDR_CTRL, 32'h4DB);
    repeat (20) src.pulse(1'b1, 20, 80);
    n0 = ls_cnt;
    repeat (10) src.pulse(1'b1, 20, 80);
    `CHK("scaled lines", 1'b1, (ls_cnt - n0 >= 18 && ls_cnt - n0 <= 22))
    rchk(ADDR_SC_RATE, 32'h61A80, "scaled rate");
    rchk(ADDR_SC_JIT, 32'h0, "scaled jitter");
    $display("stats test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_edge();
    t_level();
    t_free();
    t_stats();
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
